/* logic/bcc_pkg.sv */
// constants and carrier types for the bcd up/down counter with compare
// assumes a single 50 MHz clock and 3-level pins split into hi/lo detects
//
// Behaviour
// [RL1] load finishes within 5ms after release
// [RL2] equal and zero undefined during preset
// [RL3] compare is combinational, may glitch
// [RL4] controller spaces preset and reset 5ms apart
// [RL5] simultaneous presets load same value both
// [RL6] direction held stable around count edges
// [RL7] controller delays equal 1us into reset
// [RL8] equal-triggered reload takes four digit periods
// [RL9] compare register kept; reset clears it only if presetting
// [RL10] preset and display inputs are 3-level
// [RL11] counter preset low keeps port off
// [RL12] loads sequenced by internal oscillator only
// [RL13] count edge steps up or down
// [RL14] reset zeroes counter, register if presetting
// [RL15] preset starts at msd, resamples per cycle
// [RL16] store low copies counter to latches
// [RL17] equal low on match, zero low on 0
package bcc_pkg;
   // scan phase length: 2.5 kHz oscillator, one phase per pulse
   localparam int CLK_PERIOD_NS = 20;
   localparam int SCAN_PHASE_NS = 400000;
   localparam int SCAN_PHASE_CYC = SCAN_PHASE_NS / CLK_PERIOD_NS;
   // worst load time after release, for checking
   localparam int LOAD_MAX_NS = 5000000;
   localparam int LOAD_MAX_CYC = LOAD_MAX_NS / CLK_PERIOD_NS;
   localparam logic [1:0] PHASE_MSD = 2'h3; // most_significant_digit_phase
   localparam logic [1:0] PHASE_LSD = 2'h0; // least_significant_digit_phase
   localparam logic [3:0] DIGIT_MAX = 4'h9;
   localparam logic [3:0] DIGIT_ZERO = 4'h0;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   // 3-level pin seen as two detectors; floating is neither
   typedef struct packed {
      logic hi;
      logic lo;
   } bcc_tri_t;
   typedef enum logic [0:0] {
      BCC_IDLE = 1'b0,
      BCC_LOAD = 1'b1
   } bcc_state_t;
   // whole block state
   typedef struct packed {
      bcc_state_t st;
      logic ld_cnt;
      logic ld_reg;
      logic [15:0] cnt;
      logic [15:0] cmp;
      logic [15:0] lat;
      logic [1:0] phase;
      logic [15:0] tmr;
      logic [1:0] ci_s;
      logic ci_prev;
      logic [1:0] ud_s;
      logic [1:0] rs_s;
      logic [1:0] sto_s;
      bcc_tri_t lc_s1;
      bcc_tri_t lc_s2;
      bcc_tri_t lr_s1;
      bcc_tri_t lr_s2;
      bcc_tri_t dm_s1;
      bcc_tri_t dm_s2;
      logic [3:0] bcd_s1;
      logic [3:0] bcd_s2;
      logic [3:0] bcd_out;
      logic bcd_oe;
      logic [3:0] digit_sel;
   } bcc_state_reg_t;
endpackage

/* logic/bcc_counter.sv */
// four-decade bcd up/down counter with compare register and scan loader
// assumes pins are asynchronous to clk; all pass two flops before use
`timescale 1ns/1ns
module bcc_counter #(
   parameter logic [15:0] SCAN_PHASE_CYCLES = 16'(bcc_pkg::SCAN_PHASE_CYC)
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic count_in,
   input wire logic up_down_in,
   input wire logic counter_reset_b,
   input wire logic store_b,
   input wire bcc_pkg::bcc_tri_t counter_preset_input,
   input wire bcc_pkg::bcc_tri_t register_preset_input,
   input wire bcc_pkg::bcc_tri_t display_mode_input,
   input wire logic [3:0] bcd_in,
   output logic [3:0] bcd_out,
   output logic bcd_oe,
   output logic [3:0] digit_sel,
   output logic [15:0] latch_value,
   output logic segments_off,
   output logic lz_blank_inhibit,
   output logic equal_b,
   output logic zero_b,
   output logic loading
);
   bcc_pkg::bcc_state_reg_t s_reg; // current state
   bcc_pkg::bcc_state_reg_t s_next; // next state
   logic count_edge; // synced rising count edge
   logic req_any; // any preset input high
   logic [3:0] load_digit; // digit written during a preset

   // one decade step with wrap, used for up and down
   function automatic logic [15:0] bcd_step(input logic [15:0] v,
                                            input logic up);
      logic [15:0] r;
      logic carry;
      r = v;
      carry = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (carry) begin
            if (up) begin
               carry = (v[i*4 +: 4] == bcc_pkg::DIGIT_MAX);
               r[i*4 +: 4] = carry ? bcc_pkg::DIGIT_ZERO
                                   : 4'(v[i*4 +: 4] + 4'h1);
            end else begin
               carry = (v[i*4 +: 4] == bcc_pkg::DIGIT_ZERO);
               r[i*4 +: 4] = carry ? bcc_pkg::DIGIT_MAX
                                   : 4'(v[i*4 +: 4] - 4'h1);
            end
         end
      end
      return r;
   endfunction

   // replace one decade selected by scan phase
   function automatic logic [15:0] put_digit(input logic [15:0] v,
                                             input logic [1:0] ph,
                                             input logic [3:0] d);
      logic [15:0] r;
      r = v;
      r[ph*4 +: 4] = d;
      return r;
   endfunction

   // edge detect reads only the second sync stage
   assign count_edge = s_reg.ci_s[1] & ~s_reg.ci_prev;
   assign req_any = s_reg.lc_s2.hi | s_reg.lr_s2.hi;
   // reset pin low forces zeros onto the load path
   assign load_digit = s_reg.rs_s[1] ? s_reg.bcd_s2
                                     : bcc_pkg::DIGIT_ZERO; // RL14

   // next-state logic
   always_comb begin
      s_next = s_reg;
      // synchronisers
      s_next.ci_s = {s_reg.ci_s[0], count_in};
      s_next.ci_prev = s_reg.ci_s[1];
      s_next.ud_s = {s_reg.ud_s[0], up_down_in};
      s_next.rs_s = {s_reg.rs_s[0], counter_reset_b};
      s_next.sto_s = {s_reg.sto_s[0], store_b};
      s_next.lc_s1 = counter_preset_input; // RL10
      s_next.lc_s2 = s_reg.lc_s1;
      s_next.lr_s1 = register_preset_input; // RL10
      s_next.lr_s2 = s_reg.lr_s1;
      s_next.dm_s1 = display_mode_input; // RL10
      s_next.dm_s2 = s_reg.dm_s1;
      s_next.bcd_s1 = bcd_in;
      s_next.bcd_s2 = s_reg.bcd_s1;
      // internal scan oscillator, never an outside signal
      if (s_reg.tmr == SCAN_PHASE_CYCLES - 16'h0001) begin
         s_next.tmr = 16'h0000; // RL12
         s_next.phase = 2'(s_reg.phase - 2'h1);
      end else begin
         s_next.tmr = 16'(s_reg.tmr + 16'h0001);
      end
      case (s_reg.st)
         bcc_pkg::BCC_IDLE: begin
            if (req_any) begin
               // restart scan at msd; capture both targets together
               s_next.st = bcc_pkg::BCC_LOAD; // RL15
               s_next.phase = bcc_pkg::PHASE_MSD; // RL15
               s_next.tmr = 16'h0000;
               s_next.ld_cnt = s_reg.lc_s2.hi; // RL5
               s_next.ld_reg = s_reg.lr_s2.hi; // RL5
            end else if (s_reg.lr_s2.lo) begin
               // display off: oscillator held, scan parked at msd
               s_next.tmr = 16'h0000;
               s_next.phase = bcc_pkg::PHASE_MSD;
            end
         end
         bcc_pkg::BCC_LOAD: begin
            // each digit taken at the trailing edge of its phase
            if (s_reg.tmr == SCAN_PHASE_CYCLES - 16'h0001) begin
               if (s_reg.ld_cnt) begin
                  s_next.cnt = put_digit(s_reg.cnt, s_reg.phase,
                                         load_digit);
               end
               if (s_reg.ld_reg) begin
                  s_next.cmp = put_digit(s_reg.cmp, s_reg.phase,
                                         load_digit); // RL9
               end
               if (s_reg.phase == bcc_pkg::PHASE_LSD) begin // RL8
                  // full cycle done: resample, repeat while held
                  s_next.ld_cnt = s_reg.lc_s2.hi; // RL15
                  s_next.ld_reg = s_reg.lr_s2.hi; // RL15
                  if (!req_any) begin
                     s_next.st = bcc_pkg::BCC_IDLE; // RL1
                  end
               end
            end
         end
         default: begin
            s_next.st = bcc_pkg::BCC_IDLE;
         end
      endcase
      // counting, held off by reset and counter preset
      if (!s_reg.rs_s[1]) begin
         s_next.cnt = bcc_pkg::COUNT_ZERO; // RL14
      end else if (count_edge && !(s_reg.st == bcc_pkg::BCC_LOAD
                                   && s_reg.ld_cnt)) begin
         s_next.cnt = bcd_step(s_reg.cnt, s_reg.ud_s[1]); // RL13
      end
      // store low keeps latches following the counter
      if (!s_reg.sto_s[1]) begin
         s_next.lat = s_reg.cnt; // RL16
      end
      // port drives only in normal mode, never while loading
      s_next.bcd_oe = (s_reg.st == bcc_pkg::BCC_IDLE) && !req_any
                      && !s_reg.lc_s2.lo && !s_reg.lr_s2.lo; // RL11
      s_next.bcd_out = s_reg.lat[s_reg.phase*4 +: 4];
      // digit strobe; off when display is off
      s_next.digit_sel = s_reg.lr_s2.lo ? 4'h0
                                        : 4'(4'h1 << s_reg.phase);
   end

   // state register; all constants on reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // compare is plain xor logic; glitches while loading are expected
   assign equal_b = |(s_reg.cnt ^ s_reg.cmp); // RL3 RL17
   assign zero_b = |s_reg.cnt; // RL17
   // outputs are not meaningful while this is high
   assign loading = (s_reg.st == bcc_pkg::BCC_LOAD); // RL2
   assign bcd_out = s_reg.bcd_out;
   assign bcd_oe = s_reg.bcd_oe;
   assign digit_sel = s_reg.digit_sel;
   assign latch_value = s_reg.lat;
   assign segments_off = s_reg.dm_s2.hi;
   assign lz_blank_inhibit = s_reg.dm_s2.lo;

   // load length counter, only for checking
   logic [31:0] rel_cnt;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rel_cnt <= 32'h0000_0000;
      end else if (loading && !req_any) begin
         rel_cnt <= 32'(rel_cnt + 32'h0000_0001);
      end else begin
         rel_cnt <= 32'h0000_0000;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   AST_LOAD_TIME: assert property ( // RL1
      rel_cnt <= 32'(bcc_pkg::LOAD_MAX_CYC))
      else $error("load ran past its limit");
   AST_EQUAL_MATCH: assert property ( // RL17
      (s_reg.cnt == s_reg.cmp) == !equal_b && (s_reg.cnt == 16'h0000)
      == !zero_b)
      else $error("compare outputs wrong");
   AST_REG_KEPT: assert property ( // RL9
      !(loading && s_reg.ld_reg) |=> s_reg.cmp == $past(s_reg.cmp))
      else $error("register changed without preset");
   AST_PORT_OFF: assert property ( // RL11
      s_reg.lc_s2.lo |=> !bcd_oe)
      else $error("port driven with preset input low");
   AST_COUNT_STEP: assert property ( // RL13
      count_edge && !loading && s_reg.rs_s[1]
      |=> s_reg.cnt == bcd_step($past(s_reg.cnt), $past(s_reg.ud_s[1])))
      else $error("count edge not applied");
   AST_RESET_ZERO: assert property ( // RL14
      !s_reg.rs_s[1] |=> s_reg.cnt == 16'h0000)
      else $error("counter not cleared by reset");
   AST_LOAD_START: assert property ( // RL15
      !loading && req_any
      |=> loading && s_reg.phase == bcc_pkg::PHASE_MSD
      && s_reg.tmr == 16'h0000)
      else $error("preset did not restart at msd");
   AST_BOTH_LOAD: assert property ( // RL5
      !loading && s_reg.lc_s2.hi && s_reg.lr_s2.hi
      |=> s_reg.ld_cnt && s_reg.ld_reg)
      else $error("simultaneous presets split");
   AST_STORE: assert property ( // RL16
      !s_reg.sto_s[1] |=> latch_value == $past(s_reg.cnt))
      else $error("store did not copy counter");
endmodule // bcc_counter

/* tb/bcc_thumbwheel.sv */
// thumbwheel switch bank feeding the bcd port of the counter
// assumes digit_sel is one-hot, bit 3 strobing the most significant wheel
`timescale 1ns/1ns
module bcc_thumbwheel (
   input wire logic [3:0] digit_sel,
   input wire logic [15:0] wheel_value,
   output logic [3:0] bcd_in
);
   // diode-or of strobed wheels; pull-downs give 0 when none strobed
   always_comb begin
      bcd_in = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (digit_sel[i]) begin
            bcd_in = bcd_in | wheel_value[i*4 +: 4];
         end
      end
   end
endmodule // bcc_thumbwheel

/* tb/tb.sv */
// self-checking bench for the bcd counter with compare
// assumes a short scan phase of 8 cycles set through the parameter
`timescale 1ns/1ns
module tb;
   localparam bcc_pkg::bcc_tri_t FL = 2'h0; // floating
   localparam bcc_pkg::bcc_tri_t HI = 2'h2;
   localparam bcc_pkg::bcc_tri_t LO = 2'h1;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic count_in = 1'b0;
   logic up_down_in = 1'b1;
   logic counter_reset_b = 1'b1;
   logic store_b = 1'b1;
   bcc_pkg::bcc_tri_t lc = FL;
   bcc_pkg::bcc_tri_t lr = FL;
   bcc_pkg::bcc_tri_t dm = FL;
   logic [15:0] wheel = 16'h0000;
   logic [3:0] bcd_in, bcd_out, digit_sel;
   logic [15:0] latch_value;
   logic bcd_oe, segments_off, lz_blank_inhibit, equal_b, zero_b, loading;
   int mismatches = 0;
   int checks_done = 0;
   bcc_counter #(.SCAN_PHASE_CYCLES(16'h0008)) uut (.clk(clk),
      .rst_b(rst_b), .count_in(count_in), .up_down_in(up_down_in),
      .counter_reset_b(counter_reset_b), .store_b(store_b),
      .counter_preset_input(lc), .register_preset_input(lr),
      .display_mode_input(dm), .bcd_in(bcd_in), .bcd_out(bcd_out),
      .bcd_oe(bcd_oe), .digit_sel(digit_sel), .latch_value(latch_value),
      .segments_off(segments_off), .lz_blank_inhibit(lz_blank_inhibit),
      .equal_b(equal_b), .zero_b(zero_b), .loading(loading));
   bcc_thumbwheel wheels (.digit_sel(digit_sel), .wheel_value(wheel),
      .bcd_in(bcd_in));
   // 50 MHz clock
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, exp, input string what);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one count edge; direction held still around it
   task automatic pulse();
      count_in <= 1'b1;
      tick(4);
      count_in <= 1'b0;
      tick(4);
   endtask
   // store low copies counter into latches, then read them
   task automatic latch(output logic [15:0] v);
      store_b <= 1'b0;
      tick(4);
      store_b <= 1'b1;
      tick(1);
      v = latch_value;
   endtask
   // preset from the wheels; optional count edges while loading
   task automatic preset(input logic cp, rp, pul, input logic [15:0] v);
      int i;
      wheel <= v;
      lc <= cp ? HI : FL;
      lr <= rp ? HI : FL;
      for (i = 0; i < 20 && loading !== 1'b1; i++) tick(1);
      if (i == 20) begin
         chk(1'b0, 1'b1, "no load start");
         wrap_up();
      end
      lc <= FL;
      lr <= FL;
      for (i = 0; i < 400 && loading !== 1'b0; i++) begin
         count_in <= pul & (i < 24) & i[2];
         tick(1);
      end
      count_in <= 1'b0;
      if (i == 400) begin
         chk(1'b0, 1'b1, "load hangs");
         wrap_up();
      end
      tick(100);
   endtask
   task automatic t_count();
      logic [15:0] v;
      chk({equal_b, zero_b}, 2'h0, "reset flags");
      for (int k = 0; k < 3; k++) pulse();
      latch(v);
      chk(v, 16'h0003, "count up");
      chk(zero_b, 1'b1, "zero high");
      up_down_in <= 1'b0;
      tick(4);
      for (int k = 0; k < 3; k++) pulse();
      chk(zero_b, 1'b0, "zero after down");
      up_down_in <= 1'b1;
      $display("test count done");
   endtask
   task automatic t_register();
      logic [15:0] v;
      preset(1'b0, 1'b1, 1'b0, 16'h0042);
      chk(equal_b, 1'b1, "cmp only set");
      preset(1'b1, 1'b0, 1'b0, 16'h0042);
      chk(equal_b, 1'b0, "equal");
      latch(v);
      chk(v, 16'h0042, "counter load");
      counter_reset_b <= 1'b0;
      tick(4);
      counter_reset_b <= 1'b1;
      tick(100);
      chk({equal_b, zero_b}, 2'h2, "reset keeps cmp");
      $display("test register done");
   endtask
   task automatic t_both();
      logic [15:0] v;
      preset(1'b1, 1'b1, 1'b1, 16'h1234);
      latch(v);
      chk(v, 16'h1234, "both loaded");
      chk({equal_b, zero_b}, 2'h1, "flags both");
      $display("test both done");
   endtask
   // equal fed back into counter reset after a short delay: divide by n
   task automatic t_divide();
      counter_reset_b <= 1'b0;
      tick(4);
      counter_reset_b <= 1'b1;
      tick(100);
      preset(1'b0, 1'b1, 1'b0, 16'h0003);
      for (int k = 0; k < 3; k++) pulse();
      chk({equal_b, zero_b}, 2'h1, "divide match");
      // about 1us of delay from equal to the reset pulse
      tick(50);
      counter_reset_b <= 1'b0;
      tick(4);
      counter_reset_b <= 1'b1;
      tick(6);
      chk({equal_b, zero_b}, 2'h2, "divide wrap");
      $display("test divide done");
   endtask
   task automatic t_pins();
      int i;
      lc <= LO;
      tick(6);
      chk(bcd_oe, 1'b0, "port off");
      lc <= FL;
      dm <= HI;
      tick(6);
      chk(bcd_oe, 1'b1, "port on");
      chk(segments_off, 1'b1, "seg off");
      dm <= LO;
      tick(6);
      chk(lz_blank_inhibit, 1'b1, "lz inhibit");
      dm <= FL;
      // port shows the latched msd while its strobe is up
      for (i = 0; i < 40 && digit_sel !== 4'h8; i++) tick(1);
      if (i == 40) begin
         chk(1'b0, 1'b1, "no msd strobe");
         wrap_up();
      end
      chk(bcd_out, 16'h0001, "port msd");
      // register preset low: display off, strobes and port dark
      lr <= LO;
      tick(6);
      chk({digit_sel, bcd_oe}, 16'h0000, "display off");
      lr <= FL;
      tick(6);
      $display("test pins done");
   endtask
   initial begin
      tick(10);
      rst_b <= 1'b1;
      tick(5);
      t_count();
      t_register();
      t_both();
      t_divide();
      t_pins();
      wrap_up();
   end
endmodule // tb
